//--- lec_regs.sv
`timescale 1ns/10ps
// How it works
// - Trap on, double tag: reserved multicast host-only
// - Dynamic hit: AND VLAN map when bit5
// - Static hit: AND VLAN map when bit4
// - Flush scope bits 3:2 select entries
// - Scope 00 means no flush
// - Scope governs both flush triggers
// - Priority field picks DA, SA, max, min
// - Age time is period times count
// - Learn fail sets status bit 2
// - Static write into almost-full sets bit 1
// - Static write into full bucket sets bit 0
// - Status sticky until written one; bits 7:3 zero
// - Summary bit is OR of status
// - Mask one suppresses; masks reset to one
// - Flush triggers self-clear after flush
// - Index register records entry or bucket
module lec_regs (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   // Register port
   input  wire logic [11:0]                 reg_addr,
   input  wire logic [7:0]                  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [7:0]                  reg_rdata,
   // Lookup results from the table engine
   input  wire logic                        hit_valid,
   input  wire logic                        hit_static,
   input  wire logic                        hit_reserved_mc,
   input  wire logic                        double_tag_mode,
   input  wire logic [lec_pkg::LEC_NPORT-1:0] entry_port_map,
   input  wire logic [lec_pkg::LEC_NPORT-1:0] vlan_port_map,
   input  wire logic [lec_pkg::LEC_NPORT-1:0] host_port_map,
   input  wire logic [2:0]                  da_priority,
   input  wire logic [2:0]                  sa_priority,
   output logic      [lec_pkg::LEC_NPORT-1:0] fwd_port_map,
   output logic      [2:0]                  address_based_priority,
   // Table events
   input  wire logic                        learn_fail,
   input  wire logic                        static_wr_done,
   input  wire logic                        static_wr_fail,
   input  wire logic [1:0]                  bucket_fill,
   input  wire logic [11:0]                 entry_addr,
   input  wire logic [9:0]                  bucket_addr,
   // Flush and aging handshake
   input  wire logic                        flush_done,
   output logic                             flush_req,
   output logic      [1:0]                  flush_scope,
   output logic                             flush_multiple_spanning_tree,
   output logic                             age_tick,
   output logic      [7:0]                  age_period,
   output logic                             lookup_engine_summary,
   output logic                             lookup_irq
);
   import lec_pkg::*;

   logic [7:0]  ctrl1_reg;
   logic [7:0]  ctrl_b_reg;
   logic [7:0]  age_reg;
   logic [2:0]  stat_reg;
   logic [2:0]  mask_reg;
   logic [11:0] idx_reg;
   logic [31:0] sec_cnt_reg;
   lec_state_e  st_reg;
   logic [2:0]  stat_set;
   logic [2:0]  stat_clr;
   logic        wr_ctrl1;

   // Register write decode
   function automatic logic wr_at(input logic [11:0] ofs);
      wr_at = reg_wr && (reg_addr == ofs);
   endfunction : wr_at

   // Priority compare helpers
   function automatic logic [2:0] pmax(input logic [2:0] a, input logic [2:0] b);
      pmax = (a > b) ? a : b;
   endfunction : pmax

   function automatic logic [2:0] pmin(input logic [2:0] a, input logic [2:0] b);
      pmin = (a > b) ? b : a;
   endfunction : pmin

   // Flush scope field; read by the sequencer and the engine outputs
   function automatic logic [1:0] scope_of(input logic [7:0] ctrl);
      scope_of = ctrl[LEC_SCOPE_LSB +: 2];
   endfunction : scope_of

   // Egress filter: restrict the entry map by the VLAN map when enabled
   function automatic logic [LEC_NPORT-1:0] vlan_filter(input logic                 en,
                                                         input logic [LEC_NPORT-1:0] ent,
                                                         input logic [LEC_NPORT-1:0] vln);
      vlan_filter = en ? (ent & vln) : ent;
   endfunction : vlan_filter

   assign wr_ctrl1 = wr_at(LEC_CTRL1_OFS);

   // Second control register; filters start off for older software
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_b_reg <= LEC_CTRL_B_RST;
      end else if (wr_at(LEC_CTRL_B_OFS)) begin
         ctrl_b_reg <= reg_wdata;
      end
   end

   // Age period in seconds
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         age_reg <= LEC_AGE_RST;
      end else if (wr_at(LEC_AGE_OFS)) begin
         age_reg <= reg_wdata;
      end
   end

   // Interrupt mask; upper bits do not exist and read as zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_reg <= LEC_MASK_RST;
      end else if (wr_at(LEC_IMASK_OFS)) begin
         mask_reg <= reg_wdata[2:0];
      end
   end

   // First control register; flush bits are self-clearing
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl1_reg <= LEC_CTRL1_RST;
      end else if (wr_ctrl1) begin
         ctrl1_reg <= reg_wdata;
      end else if (st_reg == LEC_ST_DONE) begin
         ctrl1_reg[LEC_FLUSH_ALL_BIT] <= 1'b0;
         ctrl1_reg[LEC_FLUSH_MST_BIT] <= 1'b0;
      end
   end

   // Flush sequencer: trigger, wait for engine, then clear triggers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= LEC_ST_IDLE;
      end else begin
         case (st_reg)
            LEC_ST_IDLE: begin
               if (!wr_ctrl1 &&
                   (ctrl1_reg[LEC_FLUSH_ALL_BIT] || ctrl1_reg[LEC_FLUSH_MST_BIT])) begin
                  st_reg <= LEC_ST_FLUSH;
               end
            end
            LEC_ST_FLUSH: begin
               // Scope 00 removes nothing, so finish at once
               if (flush_done || scope_of(ctrl_b_reg) == LEC_FL_NONE) begin
                  st_reg <= LEC_ST_DONE;
               end
            end
            LEC_ST_DONE: begin
               st_reg <= LEC_ST_IDLE;
            end
            default: begin
               st_reg <= LEC_ST_IDLE;
            end
         endcase
      end
   end

   // Request level to the table engine; scope 00 never asks for work
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flush_req <= 1'b0;
      end else begin
         flush_req <= (st_reg == LEC_ST_FLUSH) &&
                      (scope_of(ctrl_b_reg) != LEC_FL_NONE);
      end
   end

   // Scope copy; the engine reads it only while the request stands
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flush_scope <= 2'b00;
      end else begin
         flush_scope <= scope_of(ctrl_b_reg);
      end
   end

   // Spanning-tree flush only when the whole-table trigger is idle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flush_multiple_spanning_tree <= 1'b0;
      end else begin
         flush_multiple_spanning_tree <= ctrl1_reg[LEC_FLUSH_MST_BIT] &&
                                         !ctrl1_reg[LEC_FLUSH_ALL_BIT];
      end
   end

   // Aging second tick; entry engine multiplies period by age count
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sec_cnt_reg <= 32'h0000_0000;
         age_tick    <= 1'b0;
         age_period  <= LEC_AGE_RST;
      end else begin
         age_period <= age_reg;
         if (sec_cnt_reg == 32'(LEC_SEC_CYCLES - 1)) begin
            sec_cnt_reg <= 32'h0000_0000;
            age_tick    <= 1'b1;
         end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
            age_tick    <= 1'b0;
         end
      end
   end

   // Forwarding map; the trap outranks any table hit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fwd_port_map <= '0;
      end else if (hit_reserved_mc && double_tag_mode && ctrl_b_reg[LEC_TRAP_BIT]) begin
         fwd_port_map <= host_port_map;
      end else if (hit_valid && hit_static) begin
         fwd_port_map <= vlan_filter(ctrl_b_reg[LEC_STA_VF_BIT], entry_port_map,
                                     vlan_port_map);
      end else if (hit_valid) begin
         fwd_port_map <= vlan_filter(ctrl_b_reg[LEC_DYN_VF_BIT], entry_port_map,
                                     vlan_port_map);
      end else begin
         fwd_port_map <= '0;
      end
   end

   // Address-based priority source select
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         address_based_priority <= 3'h0;
      end else begin
         case (ctrl_b_reg[LEC_PRIO_LSB +: 2])
            LEC_PR_DA:  address_based_priority <= da_priority;
            LEC_PR_SA:  address_based_priority <= sa_priority;
            LEC_PR_MAX: address_based_priority <= pmax(da_priority, sa_priority);
            LEC_PR_MIN: address_based_priority <= pmin(da_priority, sa_priority);
            default:    address_based_priority <= da_priority;
         endcase
      end
   end

   // Interrupt events; set wins over a same-cycle clear
   assign stat_set[LEC_LEARN_BIT] = learn_fail;
   assign stat_set[LEC_AFULL_BIT] = static_wr_done && !static_wr_fail &&
                                    (bucket_fill >= LEC_AFULL_FILL);
   assign stat_set[LEC_WFAIL_BIT] = static_wr_fail;
   assign stat_clr = wr_at(LEC_ISTAT_OFS) ? reg_wdata[2:0] : 3'h0;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stat_reg <= 3'h0;
      end else begin
         stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      end
   end

   // Index register: failed write takes bucket, almost-full takes entry
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idx_reg <= 12'h000;
      end else if (static_wr_fail) begin
         idx_reg <= {2'b00, bucket_addr};
      end else if (stat_set[LEC_AFULL_BIT]) begin
         idx_reg <= entry_addr;
      end
   end

   // Summary bit ignores the mask, so polling software still sees events
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lookup_engine_summary <= 1'b0;
      end else begin
         lookup_engine_summary <= |stat_reg;
      end
   end

   // Interrupt line, one cycle behind the status bits
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lookup_irq <= 1'b0;
      end else begin
         lookup_irq <= |(stat_reg & ~mask_reg);
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            LEC_CTRL1_OFS:  reg_rdata <= ctrl1_reg;
            LEC_CTRL_B_OFS: reg_rdata <= ctrl_b_reg;
            LEC_AGE_OFS:    reg_rdata <= age_reg;
            LEC_ISTAT_OFS:  reg_rdata <= {5'h00, stat_reg};
            LEC_IMASK_OFS:  reg_rdata <= {5'h00, mask_reg};
            LEC_IDX0_OFS:   reg_rdata <= idx_reg[7:0];
            LEC_IDX0H_OFS:  reg_rdata <= {4'h0, idx_reg[11:8]};
            default:        reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : lec_regs

//--- lec_pkg.sv
package lec_pkg;
   // Register map, byte addresses on the management port
   localparam logic [11:0] LEC_CTRL1_OFS  = 12'h0311;
   localparam logic [11:0] LEC_CTRL_B_OFS = 12'h0312;
   localparam logic [11:0] LEC_AGE_OFS    = 12'h0313;
   localparam logic [11:0] LEC_ISTAT_OFS  = 12'h0314;
   localparam logic [11:0] LEC_IMASK_OFS  = 12'h0315;
   localparam logic [11:0] LEC_IDX0_OFS   = 12'h0316;
   localparam logic [11:0] LEC_IDX0H_OFS  = 12'h0317;

   // Field positions
   localparam int LEC_TRAP_BIT      = 6;
   localparam int LEC_DYN_VF_BIT    = 5;
   localparam int LEC_STA_VF_BIT    = 4;
   localparam int LEC_FLUSH_ALL_BIT = 5;
   localparam int LEC_FLUSH_MST_BIT = 4;
   localparam int LEC_LEARN_BIT     = 2;
   localparam int LEC_AFULL_BIT     = 1;
   localparam int LEC_WFAIL_BIT     = 0;
   localparam int LEC_SCOPE_LSB     = 2;
   localparam int LEC_PRIO_LSB      = 0;

   // Bucket fill, in valid entries, from which a static write warns
   localparam logic [1:0] LEC_AFULL_FILL = 2'h2;

   // Reset values
   localparam logic [7:0] LEC_CTRL1_RST  = 8'h0c;
   localparam logic [7:0] LEC_CTRL_B_RST = 8'h00;
   localparam logic [7:0] LEC_AGE_RST    = 8'h4b;
   localparam logic [2:0] LEC_MASK_RST   = 3'h7;

   // Timing: one second of sys_clk at 100 MHz
   localparam int          LEC_CLK_HZ     = 100_000_000;
   localparam int          LEC_SEC_CYCLES = LEC_CLK_HZ;
   localparam int          LEC_NPORT      = 7;

   typedef enum logic [1:0] {
      LEC_FL_NONE = 2'b00,
      LEC_FL_DYN  = 2'b01,
      LEC_FL_STA  = 2'b10,
      LEC_FL_BOTH = 2'b11
   } lec_flush_e;

   typedef enum logic [1:0] {
      LEC_PR_DA  = 2'b00,
      LEC_PR_SA  = 2'b01,
      LEC_PR_MAX = 2'b10,
      LEC_PR_MIN = 2'b11
   } lec_prio_e;

   typedef enum logic [1:0] {
      LEC_ST_IDLE  = 2'b00,
      LEC_ST_FLUSH = 2'b01,
      LEC_ST_DONE  = 2'b11
   } lec_state_e;
endpackage : lec_pkg

//--- lec_regs_monitor.sv
`timescale 1ns/10ps
module lec_regs_monitor
   import lec_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic [11:0]            reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   hit_valid,
   input wire logic                   hit_static,
   input wire logic                   hit_reserved_mc,
   input wire logic                   double_tag_mode,
   input wire logic [LEC_NPORT-1:0]   entry_port_map,
   input wire logic [LEC_NPORT-1:0]   vlan_port_map,
   input wire logic [LEC_NPORT-1:0]   host_port_map,
   input wire logic [2:0]             da_priority,
   input wire logic [2:0]             sa_priority,
   input wire logic [LEC_NPORT-1:0]   fwd_port_map,
   input wire logic [2:0]             address_based_priority,
   input wire logic                   learn_fail,
   input wire logic                   flush_req,
   input wire logic [1:0]             flush_scope,
   input wire logic                   lookup_engine_summary,
   input wire logic                   lookup_irq
);
   logic [7:0] ctrl_sh_reg;
   logic       trap, clr_wr;
   logic [LEC_NPORT-1:0] dyn_exp, sta_exp;
   logic [2:0] pr_exp;
   logic [1:0] scope_sh;
   logic [2:0] mask_sh_reg;

   // Shadow of the control register, so expectations need no peek inside
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_sh_reg <= LEC_CTRL_B_RST;
      end else if (reg_wr && reg_addr == LEC_CTRL_B_OFS) begin
         ctrl_sh_reg <= reg_wdata;
      end
   end

   // Shadow of the interrupt mask
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_sh_reg <= LEC_MASK_RST;
      end else if (reg_wr && reg_addr == LEC_IMASK_OFS) begin
         mask_sh_reg <= reg_wdata[2:0];
      end
   end

   // Expected results of one lookup cycle
   assign trap = ctrl_sh_reg[6] && double_tag_mode && hit_reserved_mc;
   assign clr_wr = reg_wr && reg_addr == LEC_ISTAT_OFS;
   assign scope_sh = ctrl_sh_reg[3:2];
   assign dyn_exp = ctrl_sh_reg[5] ? entry_port_map & vlan_port_map : entry_port_map;
   assign sta_exp = ctrl_sh_reg[4] ? entry_port_map & vlan_port_map : entry_port_map;
   always_comb begin
      case (ctrl_sh_reg[1:0])
         2'b00: pr_exp = da_priority;
         2'b01: pr_exp = sa_priority;
         2'b10: pr_exp = (da_priority > sa_priority) ? da_priority : sa_priority;
         default: pr_exp = (da_priority > sa_priority) ? sa_priority : da_priority;
      endcase
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_trap_host: assert property (hit_valid && trap |=>
      fwd_port_map == $past(host_port_map))
      else $error("trap did not forward to host only");
   chk_dyn_map: assert property (hit_valid && !hit_static && !trap |=>
      fwd_port_map == $past(dyn_exp))
      else $error("dynamic hit map wrong");
   chk_sta_map: assert property (hit_valid && hit_static && !trap |=>
      fwd_port_map == $past(sta_exp))
      else $error("static hit map wrong");
   chk_scope_copy: assert property (!rst |=> flush_scope == $past(scope_sh))
      else $error("flush scope differs from control");
   chk_req_scope: assert property (flush_req |-> flush_scope != 2'b00)
      else $error("flush requested with empty scope");
   chk_prio_sel: assert property (!rst |=> address_based_priority == $past(pr_exp))
      else $error("address priority source wrong");
   chk_learn_sum: assert property (learn_fail |-> ##2 lookup_engine_summary)
      else $error("learn fail not reported");
   chk_sum_sticky: assert property ($fell(lookup_engine_summary) |-> $past(clr_wr, 2))
      else $error("status dropped without a clear");
   chk_irq_gated: assert property (lookup_irq |->
      lookup_engine_summary && $past(mask_sh_reg) != 3'h7)
      else $error("interrupt without an unmasked status");

   cover property (lookup_irq);
   cover property (flush_req ##[1:20] !flush_req);
   cover property (hit_valid && trap);
endmodule : lec_regs_monitor

bind lec_regs lec_regs_monitor mon_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
   .hit_valid, .hit_static, .hit_reserved_mc, .double_tag_mode, .entry_port_map,
   .vlan_port_map, .host_port_map, .da_priority, .sa_priority, .fwd_port_map,
   .address_based_priority, .learn_fail, .flush_req, .flush_scope,
   .lookup_engine_summary, .lookup_irq);

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
   import lec_pkg::*;
   logic sys_clk, rst, reg_wr, reg_rd, hit_valid, hit_static, hit_reserved_mc, double_tag_mode;
   logic learn_fail, static_wr_done, static_wr_fail, flush_done, flush_req, age_tick;
   logic flush_multiple_spanning_tree, lookup_engine_summary, lookup_irq;
   logic [11:0] reg_addr, entry_addr;
   logic [9:0]  bucket_addr;
   logic [7:0]  reg_wdata, reg_rdata, age_period;
   logic [LEC_NPORT-1:0] entry_port_map, vlan_port_map, host_port_map, fwd_port_map;
   logic [2:0]  da_priority, sa_priority, address_based_priority;
   logic [1:0]  bucket_fill, flush_scope;
   int          fail_count, n_tests;

   lec_regs dut_u (.*);

   // Free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk(reg_rdata, e);
   endtask : rdc

   task automatic ev(input logic [2:0] e);
      @(posedge sys_clk);
      {learn_fail, static_wr_done, static_wr_fail} <= e;
      @(posedge sys_clk);
      {learn_fail, static_wr_done, static_wr_fail} <= 3'b000;
   endtask : ev

   // Lookup with flags {static, reserved mc, double tag}
   task automatic fw(input logic [7:0] c, input logic [2:0] h, input logic [6:0] ef,
                     input logic [2:0] ep);
      wr(LEC_CTRL_B_OFS, c);
      @(posedge sys_clk);
      {hit_valid, hit_static, hit_reserved_mc, double_tag_mode} <= {1'b1, h};
      repeat (2) @(posedge sys_clk);
      #1;
      chk(fwd_port_map, ef);
      chk(address_based_priority, ep);
   endtask : fw

   // Engine stalls a few cycles before reporting completion
   task automatic fl(input logic [7:0] c1, input logic [1:0] sc, input logic em);
      wr(LEC_CTRL_B_OFS, {4'h0, sc, 2'b00});
      wr(LEC_CTRL1_OFS, c1);
      if (sc != 2'b00) begin
         for (int i = 0; i < 20 && flush_req !== 1'b1; i++) @(posedge sys_clk);
         repeat (3) @(posedge sys_clk);
         chk(flush_req, 1'b1);
         chk(flush_scope, sc);
         chk(flush_multiple_spanning_tree, em);
         @(posedge sys_clk);
         flush_done <= 1'b1;
         @(posedge sys_clk);
         flush_done <= 1'b0;
      end
      repeat (4) @(posedge sys_clk);
      chk(flush_req, 1'b0);
      rdc(LEC_CTRL1_OFS, LEC_CTRL1_RST);
   endtask : fl

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // Watchdog well beyond the expected two hundred or so cycles
   initial begin
      #200_000;
      fail_count++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, hit_valid, hit_static, hit_reserved_mc, double_tag_mode} = '0;
      {learn_fail, static_wr_done, static_wr_fail, flush_done} = 4'h0;
      {reg_addr, reg_wdata, entry_addr, bucket_addr, bucket_fill} = '0;
      {entry_port_map, vlan_port_map, host_port_map} = {7'h5a, 7'h33, 7'h40};
      {da_priority, sa_priority} = {3'd3, 3'd5};
      fail_count = 0;
      n_tests = 0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(LEC_CTRL_B_OFS, 8'h00);
      rdc(LEC_AGE_OFS, 8'h4b);
      rdc(LEC_ISTAT_OFS, 8'h00);
      rdc(LEC_IMASK_OFS, 8'h07);
      rdc(12'h0320, 8'h00);
      chk(age_period, 8'h4b);
      chk(age_tick, 1'b0);
      wr(LEC_AGE_OFS, 8'h01);
      rdc(LEC_AGE_OFS, 8'h01);
      chk(age_period, 8'h01);
      $display("test registers done");
      fw(8'h00, 3'b000, 7'h5a, 3'd3);
      fw(8'h21, 3'b000, 7'h12, 3'd5);
      fw(8'h12, 3'b100, 7'h12, 3'd5);
      fw(8'h13, 3'b000, 7'h5a, 3'd3);
      fw(8'h40, 3'b011, 7'h40, 3'd3);
      fw(8'h40, 3'b010, 7'h5a, 3'd3);
      fw(8'h00, 3'b011, 7'h5a, 3'd3);
      fw(8'h02, 3'b100, 7'h5a, 3'd5);
      $display("test forwarding done");
      fl(8'h2c, 2'b01, 1'b0);
      fl(8'h2c, 2'b10, 1'b0);
      fl(8'h1c, 2'b11, 1'b1);
      fl(8'h2c, 2'b00, 1'b0);
      $display("test flush done");
      ev(3'b100);
      rdc(LEC_ISTAT_OFS, 8'h04);
      chk({lookup_engine_summary, lookup_irq}, 2'b10);
      wr(LEC_IMASK_OFS, 8'h03);
      rdc(LEC_ISTAT_OFS, 8'h04);
      chk(lookup_irq, 1'b1);
      wr(LEC_ISTAT_OFS, 8'h04);
      rdc(LEC_ISTAT_OFS, 8'h00);
      chk({lookup_engine_summary, lookup_irq}, 2'b00);
      // Event and clear of the same bit in one cycle: the event wins
      @(posedge sys_clk);
      {learn_fail, reg_addr, reg_wdata, reg_wr} <= {1'b1, LEC_ISTAT_OFS, 8'h04, 1'b1};
      @(posedge sys_clk);
      {learn_fail, reg_wr} <= 2'b00;
      rdc(LEC_ISTAT_OFS, 8'h04);
      wr(LEC_ISTAT_OFS, 8'h04);
      {bucket_fill, entry_addr, bucket_addr} <= {2'd1, 12'habc, 10'h155};
      ev(3'b010);
      rdc(LEC_ISTAT_OFS, 8'h00);
      bucket_fill <= 2'd2;
      ev(3'b010);
      rdc(LEC_ISTAT_OFS, 8'h02);
      wr(LEC_IDX0_OFS, 8'hff);
      rdc(LEC_IDX0_OFS, 8'hbc);
      rdc(LEC_IDX0H_OFS, 8'h0a);
      ev(3'b001);
      rdc(LEC_ISTAT_OFS, 8'h03);
      rdc(LEC_IDX0_OFS, 8'h55);
      rdc(LEC_IDX0H_OFS, 8'h01);
      wr(LEC_ISTAT_OFS, 8'h03);
      bucket_fill <= 2'h3;
      ev(3'b010);
      rdc(LEC_ISTAT_OFS, 8'h02);
      rdc(LEC_IDX0_OFS, 8'hbc);
      chk({lookup_engine_summary, lookup_irq}, 2'b10);
      wr(LEC_IMASK_OFS, 8'hf8);
      rdc(LEC_IMASK_OFS, 8'h00);
      chk(lookup_irq, 1'b1);
      $display("test interrupts done");
      stop_test();
   end
endmodule : testbench
